// ### rtl/selectable_serial_interface.v
// selectable usart / spi / i2c / i2s engine with shared fifo
//
// Notes on behaviour
// - usart, spi and i2s data use the shared fifo; i2c bypasses it
// - spi frames of 1 to 16 bits; longer ones chained by software
// - spi uses separate tx and rx fifos of eight entries, dma serviceable
// - spi master may transmit while discarding receive data
// - up to four slave selects, input or output, selectable polarity
// - i2c master, slave and monitor roles each with own dma request
// - several slave addresses; one qualified by mask or range
// - 10-bit addressing: hardware acks header, software finishes address
// - slave address compare runs on the chip clock; match wakes device
// - usart 7, 8 or 9 data bits, one or two stop bits
// - usart parity odd, even or none, generated and checked, errors flagged
// - async oversampling programmable from 5 to 16 clocks per bit
// - receive bits voted 2 of 3, noise flagged on disagreement
// - 9-bit multidrop: ninth bit marks address, software compares
// - rts/cts automatic flow, delta cts detect, transmit disable
// - usart events: rx/tx ready, idle, break, framing, parity, overrun, etc
// - usart generates and detects break
// - usart tx and rx fifos of sixteen entries, dma serviceable
// - i2s data 4 to 32 bits, common; pair may run mono
// - only first i2s pair may be master; others slave, shared settings
// - i2s bit clock and word select invertible; left or right justified
`default_nettype none
`include "ssi_map.vh"

// ------------------------------------------------------------
// fifo with registered flags and a programmable fill limit
// ------------------------------------------------------------
module ssi_fifo #(
  parameter W = 32,
  parameter D = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rstn,
  input wire clr,
  input wire [AW:0] lim,
  input wire [W-1:0] in_data,
  input wire in_valid,
  output reg in_ready,
  output wire [W-1:0] out_data,
  output reg out_valid,
  input wire out_ready
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp;
  reg [AW-1:0] rp;
  reg [AW:0] cnt;
  wire wr = in_valid && in_ready;
  wire rd = out_valid && out_ready;
  wire [AW:0] next_cnt = cnt + {{AW{1'h0}}, wr} - {{AW{1'h0}}, rd};
  assign out_data = mem[rp];
  always @(posedge clk) begin
    if (wr) mem[wp] <= in_data;
  end
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp <= {AW{1'h0}};
      rp <= {AW{1'h0}};
      cnt <= {(AW+1){1'h0}};
      in_ready <= 1'h1;
      out_valid <= 1'h0;
    end else if (clr) begin
      wp <= {AW{1'h0}};
      rp <= {AW{1'h0}};
      cnt <= {(AW+1){1'h0}};
      in_ready <= 1'h1;
      out_valid <= 1'h0;
    end else begin
      if (wr) wp <= wp + 1'h1;
      if (rd) rp <= rp + 1'h1;
      cnt <= next_cnt;
      in_ready <= next_cnt < lim;
      out_valid <= next_cnt != {(AW+1){1'h0}};
    end
  end
endmodule // ssi_fifo

// ------------------------------------------------------------
// top
// ------------------------------------------------------------
module selectable_serial_interface (
  // clock and reset
  input wire clk,
  input wire rstn,
  // function select
  input wire [2:0] fn_sel,
  // transmit stream
  input wire [31:0] tx_data,
  input wire tx_valid,
  output wire tx_ready,
  // receive stream
  output reg [31:0] rx_data,
  output reg rx_valid,
  input wire rx_ready,
  output reg dma_tx_req,
  output reg dma_rx_req,
  // usart config
  input wire [15:0] u_div,
  input wire [3:0] u_osr,
  input wire [1:0] u_len,
  input wire u_stop2,
  input wire [1:0] u_par,
  input wire u_flow_en,
  input wire u_tx_dis,
  input wire u_break,
  // usart pins
  input wire rxd,
  input wire cts_n,
  output reg txd,
  output reg rts_n,
  // usart events
  output reg u_rx_rdy,
  output reg u_tx_rdy,
  output reg u_rx_idle,
  output reg u_brk_chg,
  output reg u_brk,
  output reg u_frm_err,
  output reg u_par_err,
  output reg u_ovr,
  output reg u_unr,
  output reg u_dcts,
  output reg u_noise,
  output reg u_addr_chr,
  // spi config
  input wire [3:0] s_len,
  input wire [7:0] s_div,
  input wire s_rx_ign,
  input wire [3:0] s_sel_en,
  input wire [3:0] s_sel_pol,
  // spi pins
  input wire miso,
  output reg sck,
  output reg mosi,
  input wire [3:0] ssel_i,
  output reg [3:0] ssel_o,
  output reg [3:0] ssel_oe,
  output reg [3:0] s_sel_seen,
  // i2c config
  input wire i_slv_en,
  input wire i_mon_en,
  input wire i_mst_en,
  input wire [6:0] i_addr0,
  input wire [6:0] i_addr1,
  input wire [6:0] i_addr2,
  input wire [6:0] i_qual,
  input wire i_range,
  // i2c pins
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe,
  // i2c events
  output reg [7:0] i_data,
  output reg i_match,
  output reg i_ten_bit,
  output reg i_wake,
  output reg i_dma_slv,
  output reg i_dma_mon,
  output reg i_dma_mst,
  // i2s config
  input wire [4:0] i2s_len,
  input wire [7:0] i2s_div,
  input wire i2s_mst,
  input wire i2s_mono,
  input wire i2s_sck_inv,
  input wire i2s_ws_inv,
  input wire i2s_rjust,
  // i2s pins
  input wire i2s_sck_i,
  input wire i2s_ws_i,
  output reg i2s_sck_o,
  output reg i2s_ws_o,
  output reg i2s_clk_oe,
  output reg i2s_sd
);
  function par9(input [8:0] d, input [1:0] len);
    par9 = ^(d & (len == 2'h0 ? 9'h07f : len == 2'h1 ? 9'h0ff : 9'h1ff));
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  wire [10:0] pin_a = {ssel_i, i2s_ws_i, i2s_sck_i, sda_i, scl_i, miso, cts_n, rxd};
  reg [10:0] s1;
  reg [10:0] s2;
  genvar g;
  generate
    for (g = 0; g < 11; g = g + 1) begin : g_sync
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          s1[g] <= `LINE_IDLE;
          s2[g] <= `LINE_IDLE;
        end else begin
          s1[g] <= pin_a[g];
          s2[g] <= s1[g];
        end
      end
    end
  endgenerate
  wire rx_s = s2[0];
  wire cts_s = s2[1];
  wire miso_s = s2[2];
  wire scl_s = s2[3];
  wire sda_s = s2[4];
  wire bck_s = s2[5];
  wire ws_s = s2[6];

  // ------------------------------------------------------------
  // function select and shared fifo
  // ------------------------------------------------------------
  wire is_u = fn_sel == `FN_USART;
  wire is_s = fn_sel == `FN_SPI;
  wire is_i = fn_sel == `FN_I2C;
  wire is_2 = fn_sel == `FN_I2S;
  wire uses_fifo = is_u || is_s || is_2;
  reg [2:0] fn_q;
  // a new function starts from empty fifos
  wire clr = fn_sel != fn_q;
  wire [4:0] lim = is_u ? `LIM_USART : `LIM_SHORT;
  wire [31:0] tf_data;
  wire tf_valid;
  wire u_pop;
  wire s_pop;
  wire w_pop;
  wire [31:0] rf_data;
  wire rf_valid;
  wire rf_rdy;
  reg u_push;
  reg [31:0] u_pdat;
  reg s_push;
  reg [31:0] s_pdat;
  wire rf_out_rdy = !rx_valid || rx_ready;
  ssi_fifo #(.W(32), .D(16), .AW(4)) u_txf (
    .clk(clk), .rstn(rstn), .clr(clr), .lim(lim),
    .in_data(tx_data), .in_valid(tx_valid && uses_fifo), .in_ready(tx_ready),
    .out_data(tf_data), .out_valid(tf_valid), .out_ready(u_pop || s_pop || w_pop)
  );
  ssi_fifo #(.W(32), .D(16), .AW(4)) u_rxf (
    .clk(clk), .rstn(rstn), .clr(clr), .lim(lim),
    .in_data(is_u ? u_pdat : s_pdat), .in_valid(u_push || s_push), .in_ready(rf_rdy),
    .out_data(rf_data), .out_valid(rf_valid), .out_ready(rf_out_rdy)
  );
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fn_q <= 3'h0;
      rx_valid <= 1'h0;
      rx_data <= 32'h0000_0000;
      dma_tx_req <= 1'h0;
      dma_rx_req <= 1'h0;
    end else begin
      fn_q <= fn_sel;
      if (clr) rx_valid <= 1'h0;
      else if (rf_valid && rf_out_rdy) begin
        rx_valid <= 1'h1;
        rx_data <= rf_data;
      end else if (rx_ready) rx_valid <= 1'h0;
      dma_tx_req <= uses_fifo && tx_ready;
      dma_rx_req <= uses_fifo && rf_valid;
    end
  end

  // ------------------------------------------------------------
  // usart
  // ------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_START = 3'h1;
  localparam [2:0] ST_DATA = 3'h2;
  localparam [2:0] ST_PAR = 3'h3;
  localparam [2:0] ST_STOP = 3'h4;
  reg [15:0] bdc;
  wire bt = is_u && bdc == u_div;
  wire [3:0] nb = 4'h6 + {2'h0, u_len};
  reg [2:0] ts;
  reg [3:0] tos;
  reg [3:0] tbn;
  reg [8:0] tsh;
  reg tpar;
  wire tend = bt && tos == u_osr;
  wire u_go = is_u && tf_valid && !u_tx_dis && !(u_flow_en && cts_s) && !u_break;
  assign u_pop = ts == ST_IDLE && u_go;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bdc <= 16'h0000;
      ts <= ST_IDLE;
      tos <= 4'h0;
      tbn <= 4'h0;
      tsh <= 9'h1ff;
      tpar <= 1'h0;
      txd <= `LINE_IDLE;
      u_tx_rdy <= 1'h0;
      u_unr <= 1'h0;
    end else begin
      bdc <= (bdc == u_div || !is_u) ? 16'h0000 : bdc + 16'h0001;
      u_tx_rdy <= 1'h0;
      u_unr <= 1'h0;
      if (ts != ST_IDLE && bt) tos <= tend ? 4'h0 : tos + 4'h1;
      // break holds the line low whatever the engine does
      txd <= u_break ? 1'h0 : ts == ST_START ? 1'h0 : ts == ST_DATA ? tsh[0] :
             ts == ST_PAR ? tpar : 1'h1;
      case (ts)
        ST_IDLE: begin
          tos <= 4'h0;
          tbn <= 4'h0;
          if (u_go) begin
            ts <= ST_START;
            tsh <= tf_data[8:0];
            tpar <= par9(tf_data[8:0], u_len) ^ (u_par == `PAR_ODD);
            u_tx_rdy <= 1'h1;
          end
        end
        ST_START: if (tend) ts <= ST_DATA;
        ST_DATA: if (tend) begin
          tsh <= tsh >> 1;
          if (tbn == nb) begin
            tbn <= 4'h0;
            ts <= u_par[1] ? ST_PAR : ST_STOP;
          end else tbn <= tbn + 4'h1;
        end
        ST_PAR: if (tend) ts <= ST_STOP;
        ST_STOP: if (tend) begin
          if (tbn[0] == u_stop2) begin
            ts <= ST_IDLE;
            u_unr <= !tf_valid;
          end else tbn <= 4'h1;
        end
        default: ts <= ST_IDLE;
      endcase
    end
  end

  reg [2:0] rs;
  reg [3:0] ros;
  reg [3:0] rbn;
  reg [8:0] rsh;
  reg [2:0] vs;
  reg nz;
  reg pe;
  reg idl;
  reg cts_q;
  wire [3:0] mid = {1'h0, u_osr[3:1]};
  wire rend = bt && ros == u_osr;
  wire vote = (vs[0] & vs[1]) | (vs[1] & vs[2]) | (vs[0] & vs[2]);
  wire noisy = !(vs == 3'h0 || vs == 3'h7);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rs <= ST_IDLE;
      ros <= 4'h0;
      rbn <= 4'h0;
      rsh <= 9'h000;
      vs <= 3'h7;
      nz <= 1'h0;
      pe <= 1'h0;
      idl <= 1'h1;
      cts_q <= `LINE_IDLE;
      rts_n <= 1'h0;
      u_push <= 1'h0;
      u_pdat <= 32'h0000_0000;
      {u_rx_rdy, u_rx_idle, u_brk_chg, u_brk, u_frm_err, u_par_err} <= 6'h00;
      {u_ovr, u_dcts, u_noise, u_addr_chr} <= 4'h0;
    end else begin
      {u_push, u_rx_rdy, u_rx_idle, u_brk_chg, u_frm_err, u_par_err} <= 6'h00;
      {u_ovr, u_noise, u_addr_chr} <= 3'h0;
      cts_q <= cts_s;
      u_dcts <= is_u && cts_q != cts_s;
      rts_n <= u_flow_en && !rf_rdy;
      if (bt) ros <= rend ? 4'h0 : ros + 4'h1;
      if (bt && (ros == mid - 4'h1 || ros == mid || ros == mid + 4'h1))
        vs <= {vs[1:0], rx_s};
      if (rend && rs != ST_IDLE) nz <= nz | noisy;
      case (rs)
        ST_IDLE: begin
          if (u_brk && rx_s) begin
            u_brk <= 1'h0;
            u_brk_chg <= 1'h1;
          end
          if (is_u && !rx_s && !u_brk) begin
            rs <= ST_START;
            ros <= 4'h0;
            rbn <= 4'h0;
            rsh <= 9'h000;
            nz <= 1'h0;
            pe <= 1'h0;
            idl <= 1'h0;
          end else if (rend && !idl) begin
            rbn <= rbn + 4'h1;
            if (rbn == `IDLE_BITS) begin
              idl <= 1'h1;
              u_rx_idle <= 1'h1;
            end
          end
        end
        ST_START: if (rend) rs <= vote ? ST_IDLE : ST_DATA;
        ST_DATA: if (rend) begin
          rsh[rbn] <= vote;
          if (rbn == nb) begin
            rbn <= 4'h0;
            rs <= u_par[1] ? ST_PAR : ST_STOP;
          end else rbn <= rbn + 4'h1;
        end
        ST_PAR: if (rend) begin
          pe <= vote ^ par9(rsh, u_len) ^ (u_par == `PAR_ODD);
          rs <= ST_STOP;
        end
        ST_STOP: if (rend) begin
          rs <= ST_IDLE;
          u_pdat <= {16'h0000, nz | noisy, pe, !vote, 4'h0, rsh};
          u_push <= rf_rdy;
          u_ovr <= !rf_rdy;
          u_rx_rdy <= rf_rdy;
          u_frm_err <= !vote;
          u_par_err <= pe;
          u_noise <= nz | noisy;
          u_addr_chr <= u_len == 2'h2 && rsh[8];
          if (!vote && rsh == 9'h000) begin
            u_brk <= 1'h1;
            u_brk_chg <= 1'h1;
          end
        end
        default: rs <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // spi master, mode 0; s_div of 2 or more keeps miso sampling safe
  // ------------------------------------------------------------
  reg sst;
  reg sph;
  reg [7:0] sdc;
  reg [3:0] sbc;
  reg [15:0] stsh;
  reg [15:0] srsh;
  wire stk = sdc == s_div;
  assign s_pop = is_s && !sst && tf_valid;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {sst, sph, sck, mosi, s_push} <= 5'h00;
      sdc <= 8'h00;
      sbc <= 4'h0;
      stsh <= 16'h0000;
      srsh <= 16'h0000;
      s_pdat <= 32'h0000_0000;
      ssel_o <= 4'h0;
      ssel_oe <= 4'h0;
      s_sel_seen <= 4'h0;
    end else begin
      s_push <= 1'h0;
      sdc <= (stk || !sst) ? 8'h00 : sdc + 8'h01;
      mosi <= stsh[15];
      ssel_o <= ({4{sst}} & s_sel_en) ~^ s_sel_pol;
      ssel_oe <= {4{is_s}} & s_sel_en;
      s_sel_seen <= s2[10:7] ~^ s_sel_pol;
      if (s_pop) begin
        sst <= 1'h1;
        sph <= 1'h0;
        sbc <= s_len;
        stsh <= tf_data[15:0] << (4'hf - s_len);
        srsh <= 16'h0000;
      end else if (sst && stk) begin
        sph <= !sph;
        sck <= !sph;
        // sample on the fall: the synchronised bit has long settled by then
        if (sph) begin
          srsh <= {srsh[14:0], miso_s};
          stsh <= stsh << 1;
          sbc <= sbc - 4'h1;
          if (sbc == 4'h0) begin
            sst <= 1'h0;
            s_push <= !s_rx_ign && rf_rdy;
            s_pdat <= {16'h0000, srsh[14:0], miso_s};
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // i2c slave and monitor, off the fifo path
  // ------------------------------------------------------------
  function hit7(input [6:0] a, input [6:0] a0, input [6:0] a1, input [6:0] a2,
                input [6:0] q, input rg);
    hit7 = a == a1 || a == a2 ||
           (rg ? (a >= a0 && a <= q) : ((a ^ a0) & ~q) == 7'h00);
  endfunction
  reg scl_q;
  reg sda_q;
  reg [3:0] ibc;
  reg [7:0] ish;
  reg iadr;
  reg imat;
  reg irw;
  reg busy;
  wire i_start = is_i && scl_s && scl_q && sda_q && !sda_s;
  wire i_stop = is_i && scl_s && scl_q && !sda_q && sda_s;
  wire ten = ish[7:3] == `TEN_BIT_HDR;
  // scl edges are found by sampling on clk, so the compare relies on the free running clock
  wire ahit = i_slv_en && (ten || hit7(ish[7:1], i_addr0, i_addr1, i_addr2,
                                       i_qual, i_range));
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= `LINE_IDLE;
      sda_q <= `LINE_IDLE;
      {iadr, imat, irw, busy, sda_o, sda_oe} <= 6'h00;
      ibc <= 4'h0;
      ish <= 8'h00;
      i_data <= 8'h00;
      {i_match, i_ten_bit, i_wake, i_dma_slv, i_dma_mon, i_dma_mst} <= 6'h00;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      {i_match, i_ten_bit, i_wake, i_dma_slv, i_dma_mon} <= 5'h00;
      i_dma_mst <= is_i && i_mst_en && !busy;
      if (i_start) begin
        {ibc, iadr, imat, busy} <= 7'h0b;
      end else if (i_stop || !is_i) begin
        {busy, imat, sda_oe} <= 3'h0;
        ibc <= 4'h0;
      end else if (scl_s && !scl_q && ibc < 4'h8) begin
        ish <= {ish[6:0], sda_s};
        ibc <= ibc + 4'h1;
      end else if (!scl_s && scl_q) begin
        if (ibc == 4'h8) begin
          ibc <= 4'h9;
          i_data <= ish;
          i_dma_mon <= i_mon_en;
          if (iadr) begin
            iadr <= 1'h0;
            imat <= ahit;
            irw <= ish[0];
            sda_oe <= ahit;
            i_match <= ahit;
            i_wake <= ahit;
            i_ten_bit <= ahit && ten;
          end else if (imat && !irw) begin
            sda_oe <= 1'h1;
            i_dma_slv <= 1'h1;
          end
        end else if (ibc == 4'h9) begin
          sda_oe <= 1'h0;
          ibc <= 4'h0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // i2s transmit, one pair; 32-bit slots
  // ------------------------------------------------------------
  reg [7:0] idc;
  reg bsck;
  reg wsm;
  reg bck_q;
  reg wsp;
  reg [5:0] bpos;
  reg [31:0] wd;
  wire bck_e = bck_s ^ i2s_sck_inv;
  wire wse = i2s_mst ? wsm : ws_s ^ i2s_ws_inv;
  wire btk = idc == i2s_div;
  wire bfall = is_2 && (i2s_mst ? (btk && bsck) : (bck_q && !bck_e));
  wire newhalf = i2s_mst ? bpos == 6'h1f : wse != wsp;
  wire nxt_left = i2s_mst ? wsm : !wse;
  wire load = bfall && newhalf && (!i2s_mono || !nxt_left);
  assign w_pop = load && tf_valid;
  reg [5:0] ln;
  reg [5:0] ix;
  reg bit_now;
  always @* begin
    ln = {1'h0, i2s_len} + 6'h01;
    ix = ln - 6'h01 - bpos;
    if (i2s_rjust) bit_now = bpos >= `SLOT_BITS - ln ? wd[5'h1f - bpos[4:0]] : 1'h0;
    else bit_now = bpos < ln ? wd[ix[4:0]] : 1'h0;
  end
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idc <= 8'h00;
      {bsck, wsm, bck_q, wsp} <= 4'h0;
      bpos <= 6'h00;
      wd <= 32'h0000_0000;
      {i2s_sck_o, i2s_ws_o, i2s_clk_oe, i2s_sd} <= 4'h0;
    end else begin
      idc <= (btk || !is_2) ? 8'h00 : idc + 8'h01;
      bck_q <= bck_e;
      if (is_2 && i2s_mst && btk) bsck <= !bsck;
      i2s_sck_o <= bsck ^ i2s_sck_inv;
      i2s_ws_o <= wsm ^ i2s_ws_inv;
      i2s_clk_oe <= is_2 && i2s_mst;
      i2s_sd <= is_2 && bit_now;
      if (bfall) begin
        wsp <= wse;
        bpos <= newhalf ? 6'h00 : bpos + 6'h01;
        if (i2s_mst && newhalf) wsm <= !wsm;
        // an empty fifo sends silence rather than stale samples
        if (load) wd <= tf_valid ? tf_data : 32'h0000_0000;
      end
    end
  end
endmodule // selectable_serial_interface
`default_nettype wire

// ### rtl/ssi_map.vh
// constants shared by the selectable serial interface
`ifndef SSI_MAP_VH
`define SSI_MAP_VH
`define FN_USART 3'h1
`define FN_SPI 3'h2
`define FN_I2C 3'h3
`define FN_I2S 3'h4
`define LIM_USART 5'h10
`define LIM_SHORT 5'h08
`define PAR_ODD 2'h3
`define SLOT_BITS 6'h20
`define TEN_BIT_HDR 5'h1e
`define LINE_IDLE 1'h1
`define IDLE_BITS 4'ha
`endif

// ### tb/ssi_asserts.sv
// port assertions for the selectable serial interface
`default_nettype none
`include "ssi_map.vh"
module ssi_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // controls
  input wire logic [2:0] fn_sel,
  input wire logic u_break,
  input wire logic u_flow_en,
  input wire logic [3:0] s_sel_en,
  input wire logic i_slv_en,
  // streams
  input wire logic [31:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic dma_tx_req,
  input wire logic dma_rx_req,
  // pins and events
  input wire logic txd,
  input wire logic rts_n,
  input wire logic [3:0] ssel_oe,
  input wire logic sda_oe,
  input wire logic u_par_err,
  input wire logic i_match
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  brk_low_a: assert property ((fn_sel == `FN_USART && u_break) [*3] |-> !txd)
    else $error("txd high during break");
  i2c_bypass_a: assert property (
    (fn_sel == `FN_I2C) [*3] |-> !(rx_valid || dma_tx_req || dma_rx_req))
    else $error("fifo active under i2c");
  rx_hold_a: assert property (
    $stable(fn_sel) && rx_valid && !rx_ready ##1 $stable(fn_sel) |-> rx_valid && $stable(rx_data))
    else $error("rx word lost before taken");
  ssel_drive_a: assert property (
    ($stable(fn_sel) && $stable(s_sel_en)) [*2] |-> ssel_oe == (fn_sel == `FN_SPI ? s_sel_en : 4'h0))
    else $error("select enables wrong");
  sda_quiet_a: assert property ((fn_sel != `FN_I2C) [*3] |-> !sda_oe)
    else $error("sda driven outside i2c");
  rts_free_a: assert property ((!u_flow_en) [*2] |-> !rts_n)
    else $error("rts raised without flow control");
  match_gate_a: assert property ((!i_slv_en) [*3] |-> !i_match)
    else $error("address match with slave off");
  par_pulse_a: assert property (u_par_err |=> !u_par_err)
    else $error("parity event longer than one cycle");
  cover property (rx_valid && rx_ready);
  cover property (u_par_err);
  cover property (u_break && !txd);
endmodule // ssi_asserts
bind selectable_serial_interface ssi_asserts u_chk (.clk, .rstn, .fn_sel, .u_break, .u_flow_en,
  .s_sel_en, .i_slv_en, .rx_data, .rx_valid, .rx_ready, .dma_tx_req, .dma_rx_req, .txd,
  .rts_n, .ssel_oe, .sda_oe, .u_par_err, .i_match);
`default_nettype wire

// ### tb/uart_peer.sv
// usart line partner: sends characters and captures what the block sends
`default_nettype none
module uart_peer #(
  parameter int BIT_NS = 400
) (
  // line from the block
  input wire logic txd,
  // line to the block, idle high
  output var logic rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  int nb = 8;
  int nchar = 0;
  bit par_on = 1'h0;
  logic [8:0] got = 9'h000;
  logic got_par = 1'h0;
  initial rxd = 1'h1;
  // mid-bit sampling; a break shows up as one all-zero capture
  always @(negedge txd) begin : grab
    int i;
    #(BIT_NS / 2);
    got = 9'h000;
    for (i = 0; i < nb; i++) begin
      #(BIT_NS);
      got[i] = txd;
    end
    if (par_on) begin
      #(BIT_NS);
      got_par = txd;
    end
    #(BIT_NS);
    nchar++;
  end
  task automatic send(input logic [8:0] d, input logic pb);
    int i;
    rxd = 1'h0;
    #(BIT_NS);
    for (i = 0; i < nb; i++) begin
      rxd = d[i];
      #(BIT_NS);
    end
    if (par_on) begin
      rxd = pb;
      #(BIT_NS);
    end
    rxd = 1'h1;
    #(BIT_NS * 2);
  endtask
endmodule // uart_peer
`default_nettype wire

// ### tb/selectable_serial_interface_bench.sv
// self-checking bench for the selectable serial interface
`default_nettype none
`include "ssi_map.vh"
module selectable_serial_interface_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, rstn, tx_valid, rx_ready, u_stop2, u_flow_en, u_tx_dis, u_break, cts_n;
  logic s_rx_ign, i_slv_en, i_mon_en, i_mst_en, i_range, i2s_mst, i2s_mono, i2s_sck_inv;
  logic i2s_ws_inv, i2s_rjust, scl_i, sda_i, i2s_sck_i, i2s_ws_i, rxd;
  logic [2:0] fn_sel;
  logic [31:0] tx_data, rx_data;
  logic [15:0] u_div;
  logic [3:0] u_osr, s_len, s_sel_en, s_sel_pol, ssel_i, ssel_o, ssel_oe, s_sel_seen;
  logic [1:0] u_len, u_par;
  logic [7:0] s_div, i2s_div, i_data;
  logic [6:0] i_addr0, i_addr1, i_addr2, i_qual;
  logic [4:0] i2s_len;
  logic tx_ready, rx_valid, dma_tx_req, dma_rx_req, txd, rts_n, u_rx_rdy, u_tx_rdy, u_rx_idle;
  logic u_brk_chg, u_brk, u_frm_err, u_par_err, u_ovr, u_unr, u_dcts, u_noise, u_addr_chr;
  logic sck, mosi, sda_o, sda_oe, i_match, i_ten_bit, i_wake, i_dma_slv, i_dma_mon;
  logic i_dma_mst, i2s_sck_o, i2s_ws_o, i2s_clk_oe, i2s_sd;
  // spi loopback: what goes out comes back
  wire miso = mosi;
  int n_errors = 0;
  int total_checks = 0;
  always #25 clk = ~clk;
  selectable_serial_interface u_dut (.*);
  uart_peer #(.BIT_NS(400)) u_peer (.txd, .rxd);
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic lost(input string what);
    n_errors++;
    $display("[FAIL] %s expected event seen none", what);
    report_and_stop;
  endtask
  task automatic pick(input logic [2:0] f);
    @(negedge clk);
    fn_sel = f;
    repeat (4) @(negedge clk);
  endtask
  task automatic push(input logic [31:0] d);
    int i;
    @(negedge clk);
    tx_data = d;
    tx_valid = 1'h1;
    for (i = 0; i < 5000 && tx_ready !== 1'h1; i++) @(negedge clk);
    if (tx_ready !== 1'h1) lost("tx_ready");
    @(negedge clk);
    tx_valid = 1'h0;
  endtask
  // word left waiting two cycles to exercise the hold
  task automatic pull(output logic [31:0] w);
    int i;
    for (i = 0; i < 5000 && rx_valid !== 1'h1; i++) @(negedge clk);
    if (rx_valid !== 1'h1) lost("rx_valid");
    repeat (2) @(negedge clk);
    w = rx_data;
    rx_ready = 1'h1;
    @(negedge clk);
    rx_ready = 1'h0;
  endtask
  task automatic fill(output int n);
    @(negedge clk);
    tx_valid = 1'h1;
    for (n = 0; n < 40 && tx_ready === 1'h1; n++) begin
      tx_data = n;
      @(negedge clk);
    end
    tx_valid = 1'h0;
  endtask
  task automatic wait_chars(input int n);
    int i;
    for (i = 0; i < 40000 && u_peer.nchar < n; i++) @(negedge clk);
    if (u_peer.nchar < n) lost("peer chars");
  endtask
  initial begin : main
    logic [31:0] w, d;
    int k, n, base;
    {rstn, tx_valid, rx_ready, u_stop2, u_flow_en, u_tx_dis, u_break, cts_n, s_rx_ign} = '0;
    {i_slv_en, i_mon_en, i_mst_en, i_range, i2s_mst, i2s_mono, i2s_sck_inv, i2s_ws_inv} = '0;
    {i2s_rjust, i2s_sck_i, i2s_ws_i, ssel_i, fn_sel, tx_data, u_div, s_sel_pol} = '0;
    {i2s_div, i_addr0, i_addr1, i_addr2, i_qual} = '0;
    {scl_i, sda_i} = 2'h3;
    u_osr = 4'h7;
    s_len = 4'h3;
    s_div = 8'h02;
    s_sel_en = 4'h1;
    i2s_len = 5'h0f;
    repeat (6) @(negedge clk);
    rstn = 1'h1;
    pick(`FN_USART);
    for (k = 0; k < 3; k++) begin
      u_len = k[1:0];
      u_par = (k == 2) ? `PAR_ODD : {k[0], 1'h0};
      u_stop2 = k[0];
      u_peer.nb = 7 + k;
      u_peer.par_on = (k != 0);
      base = u_peer.nchar;
      push(32'h0000_00a4);
      wait_chars(base + 1);
      d = 32'h0000_00a4 & ((32'h0000_0001 << (7 + k)) - 32'h0000_0001);
      chk("tx char", d, {23'h0, u_peer.got});
      if (k != 0) chk("tx parity", {31'h0, ^d[8:0] ^ (k == 2)}, {31'h0, u_peer.got_par});
    end
    $display("test usart_tx done");
    u_len = 2'h1;
    u_par = 2'h2;
    u_peer.nb = 8;
    u_peer.send(9'h0c3, 1'h0);
    pull(w);
    chk("rx char", 32'h0000_00c3, w);
    u_peer.send(9'h0c3, 1'h1);
    pull(w);
    chk("rx parity flag", 32'h0000_40c3, w);
    u_len = 2'h2;
    u_par = 2'h0;
    u_peer.nb = 9;
    u_peer.par_on = 1'h0;
    u_peer.send(9'h1c3, 1'h0);
    pull(w);
    chk("rx nine bit", 32'h0000_01c3, w);
    $display("test usart_rx done");
    u_len = 2'h1;
    u_peer.nb = 8;
    u_flow_en = 1'h1;
    cts_n = 1'h1;
    u_tx_dis = 1'h1;
    base = u_peer.nchar;
    fill(n);
    chk("usart fifo depth", 32'd16, n);
    u_tx_dis = 1'h0;
    repeat (200) @(negedge clk);
    chk("cts stall", base, u_peer.nchar);
    cts_n = 1'h0;
    wait_chars(base + 16);
    chk("last drained", 32'h0000_000f, {23'h0, u_peer.got});
    $display("test usart_flow done");
    u_break = 1'h1;
    repeat (20) @(negedge clk);
    chk("break line", 32'h0, {31'h0, txd});
    u_break = 1'h0;
    repeat (150) @(negedge clk);
    $display("test usart_break done");
    pick(`FN_I2C);
    i_mst_en = 1'h1;
    push(32'h0000_0055);
    repeat (50) @(negedge clk);
    chk("i2c no fifo", 32'h0, {31'h0, rx_valid});
    $display("test i2c_bypass done");
    pick(`FN_SPI);
    chk("select idle", 32'h0000_000f, {28'h0, ssel_o});
    for (k = 0; k < 2; k++) begin
      s_len = k ? 4'hf : 4'h3;
      push(32'h0000_bee9);
      pull(w);
      chk("spi frame", k ? 32'h0000_bee9 : 32'h0000_0009, w);
    end
    s_rx_ign = 1'h1;
    push(32'h0000_0005);
    repeat (200) @(negedge clk);
    chk("spi rx ignored", 32'h0, {31'h0, rx_valid});
    s_div = 8'hff;
    fill(n);
    // one word is already in the shifter besides the eight queued
    chk("spi fifo depth", 32'd9, n);
    $display("test spi done");
    pick(`FN_I2S);
    i2s_mst = 1'h1;
    push(32'h0000_1234);
    repeat (40) @(negedge clk);
    chk("i2s clock drive", 32'h1, {31'h0, i2s_clk_oe});
    $display("test i2s done");
    report_and_stop;
  end
endmodule // selectable_serial_interface_bench
`default_nettype wire
